// *** logic/file_test_pattern_gen.sv ***
// Write pattern streamer and read data checker for file transfer tests.
//
// Contract
// - Write request pulses start; active until done.
// - Write when not almost full, pause otherwise.
// - Count writes; stop at computed end size.
// - Total sectors are file count times size.
// - Read enable is inverse of empty.
// - Count reads; counter drives expected pattern.
// - Sector: header dwords 0-1, pattern after.
// - Address starts name times size, increments.
// - Increment, decrement, zeros, ones, LFSR patterns.
// - LFSR seeded by header; dword 1 header.
// - LFSR taps 31, 21, 1, 0.
// - Three-bit select picks the pattern.
// - Compare reads to expected; flag mismatch.
// - FIFO data words are 32 bits.
// - Select codes 0 to 4 in order.
// - Size code 000 means 32 MB.
// - Report transferred bytes, 41 bits wide.
`timescale 1ns/10ps
module file_test_pattern_gen (
  input wire logic clk_sys,                            // System clock.
  input wire logic rstn,                               // Async reset, low.
  input wire logic cmd_start,                          // Command pulse.
  input wire tpg_pkg::cmd_s cmd,                       // Command fields.
  input wire logic wfifo_almost_full,                  // Write FIFO level.
  output logic wfifo_write_enable,                     // Write strobe.
  output logic [tpg_pkg::WORD_W-1:0] wfifo_write_word, // Write data.
  input wire logic rfifo_empty,                        // Read FIFO empty.
  output logic rfifo_read_enable,                      // Read strobe.
  input wire logic [tpg_pkg::WORD_W-1:0] rfifo_read_word, // Read data.
  output logic write_pattern_start,                    // Start pulse.
  output logic write_transfer_active,                  // Write running.
  output logic read_transfer_active,                   // Read running.
  output logic verify_fail,                            // Mismatch seen.
  output logic [tpg_pkg::BYTES_W-1:0] transferred_bytes // Bytes so far.
);

  localparam int CW = tpg_pkg::CNT_W;
  localparam int W = tpg_pkg::WORD_W;
  localparam int SW = tpg_pkg::SECT_IDX_W;

  tpg_pkg::mode_e mode_q;
  tpg_pkg::cmd_s cmd_q;
  logic [CW-1:0] transfer_counter_q;
  logic [CW-1:0] transfer_end_size_q;
  logic [CW-1:0] sector_address_q;
  logic [CW-1:0] end_dwords;
  logic [CW-1:0] start_sector;
  logic [W-1:0] expected_word;
  logic wfifo_write_enable_q;
  logic [W-1:0] wfifo_write_word_q;
  logic write_pattern_start_q;
  logic write_transfer_active_q;
  logic read_transfer_active_q;
  logic verify_fail_q;
  logic [tpg_pkg::BYTES_W-1:0] transferred_bytes_q;
  logic at_end;
  logic issue_write;
  logic take_read;
  logic step;
  logic mismatch;

  // Sizes come from the live command fields so they are ready at start.
  transfer_size_calc u_size (
    .cmd(cmd),
    .end_dwords(end_dwords),
    .start_sector(start_sector)
  );

  pattern_word_gen #(
    .W(W)
  ) u_pattern_generator (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .advance(step),
    .select(cmd_q.pattern),
    .dw_idx(transfer_counter_q[SW-1:0]),
    .header({16'h0, sector_address_q}),
    .count_word(transfer_counter_q[W-1:0]),
    .word(expected_word)
  );

  // Handshake terms. Writes stop exactly at the end size.
  always_comb begin
    at_end = (transfer_counter_q == transfer_end_size_q);
    issue_write = (mode_q == tpg_pkg::ST_WRITE) && !at_end &&
                  !wfifo_almost_full;
    take_read = (mode_q == tpg_pkg::ST_READ) && !at_end && !rfifo_empty;
    step = issue_write || take_read;
    mismatch = take_read && (rfifo_read_word != expected_word);
  end

  // Read enable follows empty directly; a registered copy would let one
  // read slip past an empty FIFO, so this one output stays combinational.
  assign rfifo_read_enable = take_read;

  // Mode sequencing: a new start always wins over the running command.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mode_q <= tpg_pkg::ST_IDLE;
    end else if (cmd_start) begin
      mode_q <= cmd.write ? tpg_pkg::ST_WRITE : tpg_pkg::ST_READ;
    end else begin
      unique case (mode_q)
        tpg_pkg::ST_IDLE: mode_q <= tpg_pkg::ST_IDLE;
        tpg_pkg::ST_WRITE: begin
          if (at_end) begin
            mode_q <= tpg_pkg::ST_IDLE;
          end
        end
        tpg_pkg::ST_READ: begin
          if (at_end) begin
            mode_q <= tpg_pkg::ST_IDLE;
          end
        end
        default: mode_q <= tpg_pkg::ST_IDLE;
      endcase
    end
  end

  // Command fields are held for the whole transfer.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cmd_q <= '0;
      transfer_end_size_q <= tpg_pkg::CNT_RESET;
    end else if (cmd_start) begin
      cmd_q <= cmd;
      transfer_end_size_q <= end_dwords;
    end
  end

  // Word counter, shared by write and read directions.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      transfer_counter_q <= tpg_pkg::CNT_RESET;
    end else if (cmd_start) begin
      transfer_counter_q <= tpg_pkg::CNT_RESET;
    end else if (step) begin
      transfer_counter_q <= transfer_counter_q + 1'b1;
    end
  end

  // Sector address advances after the last dword of each sector.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sector_address_q <= tpg_pkg::CNT_RESET;
    end else if (cmd_start) begin
      sector_address_q <= start_sector;
    end else if (step && (&transfer_counter_q[SW-1:0])) begin
      sector_address_q <= sector_address_q + 1'b1;
    end
  end

  // Registered write port; word and strobe leave the same flop stage.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wfifo_write_enable_q <= 1'b0;
      wfifo_write_word_q <= tpg_pkg::WORD_RESET;
    end else begin
      wfifo_write_enable_q <= issue_write;
      if (issue_write) begin
        wfifo_write_word_q <= expected_word;
      end
    end
  end

  // Status flags. The start pulse marks the write command's first cycle.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      write_pattern_start_q <= 1'b0;
      write_transfer_active_q <= 1'b0;
      read_transfer_active_q <= 1'b0;
    end else begin
      write_pattern_start_q <= cmd_start && cmd.write;
      if (cmd_start) begin
        write_transfer_active_q <= cmd.write;
        read_transfer_active_q <= !cmd.write;
      end else if (at_end) begin
        write_transfer_active_q <= 1'b0;
        read_transfer_active_q <= 1'b0;
      end
    end
  end

  // Fail stays set until the next command; a mismatch in the start
  // cycle still sets it, because the mismatch branch wins over the clear.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      verify_fail_q <= 1'b0;
    end else if (mismatch) begin
      verify_fail_q <= 1'b1;
    end else if (cmd_start) begin
      verify_fail_q <= 1'b0;
    end
  end

  // Byte count is the word count times four, cut to the reported width.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      transferred_bytes_q <= '0;
    end else begin
      transferred_bytes_q <= {transfer_counter_q[tpg_pkg::BYTES_W-3:0],
                              2'h0};
    end
  end

  assign wfifo_write_enable = wfifo_write_enable_q;
  assign wfifo_write_word = wfifo_write_word_q;
  assign write_pattern_start = write_pattern_start_q;
  assign write_transfer_active = write_transfer_active_q;
  assign read_transfer_active = read_transfer_active_q;
  assign verify_fail = verify_fail_q;
  assign transferred_bytes = transferred_bytes_q;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_start_pulse_active: assert property (
    cmd_start && cmd.write |=> write_pattern_start && write_transfer_active)
    else $error("write start did not raise pulse and active");

  a_pulse_single: assert property (
    write_pattern_start && !(cmd_start && cmd.write) |=>
    !write_pattern_start)
    else $error("start pulse longer than one cycle");

  a_pause_full: assert property (
    wfifo_almost_full |=> !wfifo_write_enable)
    else $error("write issued while almost full");

  a_write_flow: assert property (
    mode_q == tpg_pkg::ST_WRITE && !at_end && !wfifo_almost_full &&
    !cmd_start |=> wfifo_write_enable && $changed(transfer_counter_q))
    else $error("write not issued while room available");

  a_end_stops: assert property (
    write_transfer_active && at_end && !cmd_start |=>
    !write_transfer_active ##1 !wfifo_write_enable)
    else $error("write did not stop at end size");

  a_read_enable: assert property (
    mode_q == tpg_pkg::ST_READ && !at_end |->
    rfifo_read_enable == !rfifo_empty)
    else $error("read enable not inverse of empty");

  a_read_count: assert property (
    rfifo_read_enable && !cmd_start |=>
    transfer_counter_q == $past(transfer_counter_q) + 1'b1)
    else $error("read did not advance counter");

  a_header_word: assert property (
    issue_write && transfer_counter_q[SW-1:0] == '0 |=>
    wfifo_write_word == $past(sector_address_q[W-1:0]))
    else $error("dword 0 does not carry sector address");

  a_fail_sticky: assert property (
    verify_fail && !cmd_start |=> verify_fail)
    else $error("fail flag dropped without new command");

  a_fail_sets: assert property (
    mismatch |=> verify_fail)
    else $error("mismatch did not raise fail");

  a_reload_start: assert property (
    cmd_start |=> transfer_counter_q == '0 && sector_address_q ==
    $past(start_sector))
    else $error("counters not reloaded at start");

  // Address, header, byte count, active-flag and quiet-strobe checks. These catch an off-by-one
  // in the sector step, which the data compare alone could hide.
  a_sector_step: assert property (
    step && !cmd_start && (&transfer_counter_q[SW-1:0]) |=>
    sector_address_q == $past(sector_address_q) + 1'b1)
    else $error("sector address did not advance after last dword");

  a_sector_hold: assert property (
    !cmd_start && !(step && (&transfer_counter_q[SW-1:0])) |=>
    $stable(sector_address_q))
    else $error("sector address moved inside a sector");

  a_header_high: assert property (
    issue_write && transfer_counter_q[SW-1:0] == SW'(tpg_pkg::HDR_HI_DW) |=>
    wfifo_write_word == {16'h0, $past(sector_address_q[CW-1:W])})
    else $error("dword 1 does not carry upper header bits");

  a_byte_count: assert property (
    step && !cmd_start |-> ##2
    transferred_bytes == $past(transferred_bytes) + 41'h4)
    else $error("byte count did not step by one word");

  a_active_hold: assert property (
    write_transfer_active && !at_end && !cmd_start |=> write_transfer_active)
    else $error("write active dropped before end size");

  a_end_quiet: assert property (
    mode_q == tpg_pkg::ST_WRITE && at_end |=> !wfifo_write_enable)
    else $error("write issued at end size");

  a_idle_quiet: assert property (
    mode_q != tpg_pkg::ST_WRITE |=> !wfifo_write_enable)
    else $error("write issued outside a write command");

  a_read_idle: assert property (
    mode_q != tpg_pkg::ST_READ |-> !rfifo_read_enable)
    else $error("read issued outside a read command");

endmodule : file_test_pattern_gen

// *** logic/pattern_word_gen.sv ***
// Per-word test pattern generator with sector header insertion and LFSR.
`timescale 1ns/10ps
module pattern_word_gen #(
  parameter int W = tpg_pkg::WORD_W                 // Data word width.
) (
  input wire logic clk_sys,                         // System clock.
  input wire logic rstn,                            // Async reset, low.
  input wire logic advance,                         // Word consumed.
  input wire logic [tpg_pkg::PSEL_W-1:0] select,    // Pattern choice.
  input wire logic [tpg_pkg::SECT_IDX_W-1:0] dw_idx, // Dword in sector.
  input wire logic [2*W-1:0] header,                // Sector header.
  input wire logic [W-1:0] count_word,              // Low counter bits.
  output logic [W-1:0] word                         // Current word.
);

  logic [W-1:0] lfsr_q;
  logic [W-1:0] lfsr_d;
  logic [W-1:0] body;
  logic [W-1:0] inc_word;

  // Feedback taps of x^31 + x^21 + x + 1.
  always_comb begin
    lfsr_d = {lfsr_q[W-2:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
  end

  // The register is reseeded from the header on dword 0 of every sector,
  // so each sector's LFSR run is independent of the one before it.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lfsr_q <= tpg_pkg::LFSR_RESET;
    end else if (advance) begin
      if (dw_idx == '0) begin
        lfsr_q <= header[W-1:0];
      end else begin
        lfsr_q <= lfsr_d;
      end
    end
  end

  // Pattern body for dwords 2 to 127.
  always_comb begin
    inc_word = {header[W-1-tpg_pkg::SECT_IDX_W:0], count_word[6:0]};
    unique case (select)
      tpg_pkg::PAT_INC: body = inc_word;
      tpg_pkg::PAT_DEC: body = ~inc_word;
      tpg_pkg::PAT_ZERO: body = '0;
      tpg_pkg::PAT_ONE: body = '1;
      tpg_pkg::PAT_LFSR: body = lfsr_d;
      default: body = inc_word;
    endcase
  end

  // Header goes into dwords 0 and 1, the body fills the rest.
  always_comb begin
    if (dw_idx == '0) begin
      word = header[W-1:0];
    end else if (dw_idx == tpg_pkg::SECT_IDX_W'(tpg_pkg::HDR_HI_DW)) begin
      word = header[2*W-1:W];
    end else begin
      word = body;
    end
  end

endmodule : pattern_word_gen

// *** logic/tpg_pkg.sv ***
// Shared constants, types and command carrier of the test pattern block.
package tpg_pkg;

  localparam int WORD_W = 32;
  localparam int CNT_W = 48;
  localparam int SECT_IDX_W = 7;
  localparam int HDR_HI_DW = 1;
  localparam int FILE_SIZE_CODE_BASE_SHIFT = 16;
  localparam int BYTE_SHIFT = 2;
  localparam int BYTES_W = 41;
  localparam int NAME_W = 16;
  localparam int FCOUNT_W = 16;
  localparam int FILE_SIZE_CODE_W = 3;
  localparam int PSEL_W = 3;
  localparam logic [CNT_W-1:0] CNT_RESET = 48'h0;
  localparam logic [WORD_W-1:0] WORD_RESET = 32'h0;
  localparam logic [WORD_W-1:0] LFSR_RESET = 32'h0;

  localparam logic [PSEL_W-1:0] PAT_INC = 3'h0;
  localparam logic [PSEL_W-1:0] PAT_DEC = 3'h1;
  localparam logic [PSEL_W-1:0] PAT_ZERO = 3'h2;
  localparam logic [PSEL_W-1:0] PAT_ONE = 3'h3;
  localparam logic [PSEL_W-1:0] PAT_LFSR = 3'h4;

  localparam logic [FILE_SIZE_CODE_W-1:0] FILE_SIZE_CODE_DEFAULT = 3'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WRITE = 2'h1,
    ST_READ = 2'h2
  } mode_e;

  typedef struct packed {
    logic write;
    logic [NAME_W-1:0] name;
    logic [FCOUNT_W-1:0] count;
    logic [FILE_SIZE_CODE_W-1:0] size_code;
    logic [PSEL_W-1:0] pattern;
  } cmd_s;

endpackage : tpg_pkg

// *** logic/transfer_size_calc.sv ***
// Decodes file size code into transfer end size and first sector address.
`timescale 1ns/10ps
module transfer_size_calc (
  input wire tpg_pkg::cmd_s cmd,                      // Live command fields.
  output logic [tpg_pkg::CNT_W-1:0] end_dwords,       // Total dwords.
  output logic [tpg_pkg::CNT_W-1:0] start_sector      // First sector.
);

  logic [4:0] sect_shift;
  logic [5:0] dw_shift;

  // Sizes are powers of two, so products reduce to shifts.
  always_comb begin
    sect_shift = 5'(tpg_pkg::FILE_SIZE_CODE_BASE_SHIFT) + 5'(cmd.size_code);
    dw_shift = 6'(sect_shift) + 6'(tpg_pkg::SECT_IDX_W);
    end_dwords = tpg_pkg::CNT_W'(cmd.count) << dw_shift;
    start_sector = tpg_pkg::CNT_W'(cmd.name) << sect_shift;
  end

endmodule : transfer_size_calc

// *** test/fifo_partner.sv ***
// Behavioural write and read FIFO pair facing the pattern block.
`timescale 1ns/10ps
module fifo_partner (
  input wire logic clk_sys,        // System clock.
  input wire logic hold_wr,        // Force almost-full.
  input wire logic wr_en,          // Write strobe.
  input wire logic [31:0] wr_word, // Write data.
  output logic almost_full,        // Write FIFO level.
  input wire logic rd_en,          // Read strobe.
  output logic empty,              // Read FIFO empty.
  output logic [31:0] rd_word      // Show-ahead data.
);
  logic [31:0] wq[$];
  logic [31:0] rq[$];
  logic [31:0] last_q = 32'h0;
  logic [2:0] cyc_q = 3'h0;
  logic e;

  initial begin
    almost_full = 1'b0;
    empty = 1'b1;
    rd_word = 32'h0;
  end

  // Stalls both sides on a fixed phase; stale read data is inverted
  // so that a read of a dead bus can never match by luck.
  always @(posedge clk_sys) begin
    if (wr_en) begin
      wq.push_back(wr_word);
    end
    if (rd_en && !empty) begin
      last_q = rq.pop_front();
    end
    cyc_q = cyc_q + 3'h1;
    e = (rq.size() == 0) || (cyc_q[1:0] == 2'h1);
    almost_full <= hold_wr | (cyc_q[2:1] == 2'h3);
    empty <= e;
    rd_word <= (rq.size() == 0) ? ~last_q : rq[0];
  end
endmodule : fifo_partner

// *** test/file_test_pattern_gen_tb.sv ***
// Self-checking bench for the file test pattern block.
`timescale 1ns/10ps
module file_test_pattern_gen_tb;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic cmd_start = 1'b0;
  tpg_pkg::cmd_s cmd = '0;
  logic hold_wr = 1'b0;
  logic af, wen, ren, emp, wps, wta, rta, vfail, af_p;
  logic [31:0] wword, rword;
  logic [40:0] bytes;
  int failures = 0;
  int tests_run = 0;
  int n;
  logic [15:0] fcount = 16'h1;

  // 20 MHz system clock.
  always #25 clk_sys = ~clk_sys;

  file_test_pattern_gen dut_u (.clk_sys(clk_sys), .rstn(rstn),
    .cmd_start(cmd_start), .cmd(cmd), .wfifo_almost_full(af),
    .wfifo_write_enable(wen), .wfifo_write_word(wword),
    .rfifo_empty(emp), .rfifo_read_enable(ren), .rfifo_read_word(rword),
    .write_pattern_start(wps), .write_transfer_active(wta),
    .read_transfer_active(rta), .verify_fail(vfail),
    .transferred_bytes(bytes));

  fifo_partner fifo_u (.clk_sys(clk_sys), .hold_wr(hold_wr),
    .wr_en(wen), .wr_word(wword), .almost_full(af), .rd_en(ren),
    .empty(emp), .rd_word(rword));

  // Expected word k of a stream that starts at sector address base.
  function automatic logic [31:0] exp_word(input logic [2:0] p,
    input logic [47:0] base, input int k);
    logic [47:0] a;
    logic [6:0] dw;
    logic [31:0] s;
    a = base + 48'(k / 128);
    dw = 7'(k % 128);
    s = a[31:0];
    for (int i = 0; i < dw; i++)
      s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    if (dw == 7'h0)
      return a[31:0];
    if (dw == 7'h1)
      return {16'h0, a[47:32]};
    case (p)
      tpg_pkg::PAT_DEC: return ~{a[24:0], dw};
      tpg_pkg::PAT_ZERO: return 32'h0;
      tpg_pkg::PAT_ONE: return 32'hFFFFFFFF;
      tpg_pkg::PAT_LFSR: return s;
      default: return {a[24:0], dw};
    endcase
  endfunction : exp_word

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  // One command pulse; a file count of one keeps a run open until aborted.
  task automatic issue(input logic wr, input logic [15:0] nm,
    input logic [2:0] sz, input logic [2:0] p);
    @(posedge clk_sys);
    cmd_start <= 1'b1;
    hold_wr <= 1'b0;
    cmd <= '{write: wr, name: nm, count: fcount, size_code: sz, pattern: p};
    @(posedge clk_sys);
    cmd_start <= 1'b0;
  endtask : issue

  // Bounded wait for read queue drained or enough words written.
  task automatic wait_q(input logic rd, input int cnt);
    for (n = 0; n < 5000; n++) begin
      if (rd ? fifo_u.rq.size() == 0 : fifo_u.wq.size() >= cnt)
        break;
      @(posedge clk_sys);
    end
    if (n == 5000) begin
      failures++;
      wrap_up();
    end
  endtask : wait_q

  // Push one read word at a falling edge and let the compare land.
  task automatic feed(input logic [31:0] w);
    fifo_u.rq.push_back(w);
    wait_q(1'b1, 0);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : feed

  // Pause must follow almost-full by one edge during writes.
  always @(posedge clk_sys) begin
    if (af_p === 1'b1 && wta === 1'b1)
      chk(wen, 1'b0);
    af_p <= af;
  end

  // Read strobe mirrors empty for the whole read.
  always @(negedge clk_sys) begin
    if (rta === 1'b1)
      chk(ren, !emp);
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    chk({wen, ren, wps, wta, rta, vfail}, 64'h0);
    rstn <= 1'b1;
    // Select codes 0 to 5, each with its own size code and file base.
    for (int p = 0; p < 6; p++) begin
      issue(1'b0, 16'h0, 3'h0, 3'h0);
      repeat (3) @(negedge clk_sys);
      chk({wta, rta, bytes}, {2'h1, 41'h0});
      fifo_u.wq.delete();
      issue(1'b1, 16'h1, 3'(p), 3'(p));
      @(negedge clk_sys);
      chk({wps, wta}, 2'h3);
      @(negedge clk_sys);
      chk({wps, wta}, 2'h1);
      wait_q(1'b0, 300);
      hold_wr <= 1'b1;
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(bytes, 41'(fifo_u.wq.size() * 4));
      for (int k = 0; k < 300; k++)
        chk(fifo_u.wq[k], exp_word(3'(p), 48'h1 << (16 + p), k));
    end
    // Read back a decrement stream with empty gaps, then corrupt it.
    @(negedge clk_sys);
    for (int k = 0; k < 300; k++)
      fifo_u.rq.push_back(exp_word(3'h1, 48'h20000, k));
    issue(1'b0, 16'h2, 3'h0, 3'h1);
    wait_q(1'b1, 0);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({rta, vfail, bytes}, {2'h2, 41'h4B0});
    feed(~exp_word(3'h1, 48'h20000, 300));
    chk(vfail, 1'b1);
    feed(exp_word(3'h1, 48'h20000, 301));
    chk(vfail, 1'b1);
    // A file count of zero ends the write at once and clears the flag.
    fcount = 16'h0;
    issue(1'b1, 16'h1, 3'h0, 3'h0);
    @(negedge clk_sys);
    chk({vfail, wta}, 2'h1);
    @(negedge clk_sys);
    chk({wps, wta, wen}, 3'h0);
    wrap_up();
  end
endmodule : file_test_pattern_gen_tb
